// ### hdl/cad_pkg.sv
// Shared constants and types for the addressing-mode decoder
package cad_pkg;

  // Prefix bytes that precede an opcode
  localparam logic [7:0] PFX_Y = 8'h90;
  localparam logic [7:0] PFX_INDY = 8'h91;
  localparam logic [7:0] PFX_IND = 8'h92;
  localparam logic [1:0] PSEL_NONE = 2'h0;
  localparam logic [1:0] PSEL_Y = 2'h1;
  localparam logic [1:0] PSEL_INDY = 2'h2;
  localparam logic [1:0] PSEL_IND = 2'h3;

  // Opcode columns (upper nibble)
  localparam logic [3:0] COL_BITREL = 4'h0;
  localparam logic [3:0] COL_BIT = 4'h1;
  localparam logic [3:0] COL_REL = 4'h2;
  localparam logic [3:0] COL_RMW_DIR = 4'h3;
  localparam logic [3:0] COL_INH_A = 4'h4;
  localparam logic [3:0] COL_INH_X = 4'h5;
  localparam logic [3:0] COL_RMW_IDX = 4'h6;
  localparam logic [3:0] COL_RMW_IDX0 = 4'h7;
  localparam logic [3:0] COL_CTRL_LO = 4'h8;
  localparam logic [3:0] COL_CTRL_HI = 4'h9;
  localparam logic [3:0] COL_IMM = 4'hA;
  localparam logic [3:0] COL_DIR = 4'hB;
  localparam logic [3:0] COL_DIR_L = 4'hC;
  localparam logic [3:0] COL_IDX_L = 4'hD;
  localparam logic [3:0] COL_IDX = 4'hE;
  localparam logic [3:0] COL_IDX0 = 4'hF;
  // Low nibble that turns the immediate column into a relative call
  localparam logic [3:0] ROW_CALLR = 4'hD;

  // Inherent control opcodes that need a side effect
  localparam logic [7:0] OP_HALT = 8'h8E;
  localparam logic [7:0] OP_WFI = 8'h8F;

  // Page zero high byte and reset values
  localparam logic [7:0] PAGE0_HI = 8'h00;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [2:0] LEN_OPCODE = 3'h1;

  // Seventeen addressing modes
  typedef enum logic [4:0] {
    M_INHERENT,
    M_IMMEDIATE,
    M_DIR_SHORT,
    M_DIR_LONG,
    M_IDX_NONE,
    M_IDX_SHORT,
    M_IDX_LONG,
    M_IND_SHORT,
    M_IND_LONG,
    M_INDIDX_SHORT,
    M_INDIDX_LONG,
    M_REL_DIR,
    M_REL_IND,
    M_BIT_DIR,
    M_BIT_IND,
    M_BITREL_DIR,
    M_BITREL_IND
  } cad_mode_t;

endpackage

// ### hdl/cad_word_asm.sv
// Byte-to-word assembler, each byte shifts in at the low half so the first of two ends in the high half
`timescale 1ns/1ps
module cad_word_asm (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Byte stream
  input wire logic i_clear,
  input wire logic i_load,
  input wire logic [7:0] i_byte,
  // Assembled word
  output logic [15:0] o_word
);

  logic [15:0] word_q;
  logic [15:0] word_d;

  always_comb begin
    word_d = word_q;
    if (i_clear) begin
      word_d = cad_pkg::WORD_RST;
    end else if (i_load) begin
      word_d = {word_q[7:0], i_byte};
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      word_q <= cad_pkg::WORD_RST;
    end else begin
      word_q <= word_d;
    end
  end

  assign o_word = word_q;

endmodule

// ### hdl/cad_ea_calc.sv
// Effective address and relative target arithmetic
`timescale 1ns/1ps
module cad_ea_calc (
  // Decoded operands
  input wire cad_pkg::cad_mode_t i_mode,
  input wire logic [15:0] i_opnd,
  input wire logic [15:0] i_ptr,
  input wire logic [7:0] i_idx,
  input wire logic [15:0] i_pc,
  // Results
  output logic [15:0] o_ea,
  output logic [15:0] o_target
);

  logic [7:0] rel_off;
  logic [15:0] idx_w;

  assign idx_w = {cad_pkg::PAGE0_HI, i_idx};

  always_comb begin
    rel_off = i_opnd[7:0];
    o_ea = {cad_pkg::PAGE0_HI, i_opnd[7:0]};
    unique case (i_mode)
      cad_pkg::M_DIR_SHORT, cad_pkg::M_BIT_DIR: o_ea = {cad_pkg::PAGE0_HI, i_opnd[7:0]};
      cad_pkg::M_DIR_LONG: o_ea = i_opnd;
      cad_pkg::M_IDX_NONE: o_ea = idx_w;
      cad_pkg::M_IDX_SHORT: o_ea = {cad_pkg::PAGE0_HI, i_opnd[7:0]} + idx_w;
      cad_pkg::M_IDX_LONG: o_ea = i_opnd + idx_w;
      cad_pkg::M_IND_SHORT, cad_pkg::M_BIT_IND: o_ea = {cad_pkg::PAGE0_HI, i_ptr[7:0]};
      cad_pkg::M_IND_LONG: o_ea = i_ptr;
      cad_pkg::M_INDIDX_SHORT: o_ea = {cad_pkg::PAGE0_HI, i_ptr[7:0]} + idx_w;
      cad_pkg::M_INDIDX_LONG: o_ea = i_ptr + idx_w;
      cad_pkg::M_REL_IND: rel_off = i_ptr[7:0];
      cad_pkg::M_BITREL_DIR: o_ea = {cad_pkg::PAGE0_HI, i_opnd[15:8]};
      cad_pkg::M_BITREL_IND: o_ea = {cad_pkg::PAGE0_HI, i_ptr[7:0]};
      default: o_ea = {cad_pkg::PAGE0_HI, i_opnd[7:0]};
    endcase
    o_target = i_pc + {{8{rel_off[7]}}, rel_off};
  end

endmodule

// ### hdl/cad_decoder.sv
// Instruction length and operand address decoder
`timescale 1ns/1ps
module cad_decoder (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Fetch stream
  input wire logic i_fetch_valid,
  input wire logic [7:0] i_fetch_byte,
  output logic o_fetch_ready,
  // Program counter load
  input wire logic i_pc_load,
  input wire logic [15:0] i_pc_value,
  output logic [15:0] o_pc,
  // Index registers from the datapath
  input wire logic [7:0] i_idx_x,
  input wire logic [7:0] i_idx_y,
  // Data memory read port
  output logic o_mem_rd,
  output logic [15:0] o_mem_addr,
  input wire logic i_mem_valid,
  input wire logic [7:0] i_mem_rdata,
  // Decoded instruction
  output logic o_dec_valid,
  input wire logic i_dec_ready,
  output logic [7:0] o_dec_opcode,
  output cad_pkg::cad_mode_t o_dec_mode,
  output logic [2:0] o_dec_len,
  output logic o_dec_use_y,
  output logic o_dec_rmw,
  output logic [7:0] o_dec_imm,
  output logic [15:0] o_dec_ea,
  output logic [15:0] o_dec_target,
  output logic [2:0] o_dec_bit,
  output logic o_dec_halt,
  output logic o_dec_wfi
);

  typedef enum logic [2:0] {
    S_OPC,
    S_OPND,
    S_PTR,
    S_CALC,
    S_OUT
  } cad_state_t;

  // Operand bytes that follow the opcode in the fetch stream
  function automatic logic [1:0] fetch_cnt(input cad_pkg::cad_mode_t m);
    unique case (m)
      cad_pkg::M_INHERENT, cad_pkg::M_IDX_NONE: fetch_cnt = 2'd0;
      cad_pkg::M_DIR_LONG, cad_pkg::M_IDX_LONG: fetch_cnt = 2'd2;
      cad_pkg::M_BITREL_DIR, cad_pkg::M_BITREL_IND: fetch_cnt = 2'd2;
      default: fetch_cnt = 2'd1;
    endcase
  endfunction

  // Pointer bytes read from data memory
  function automatic logic [1:0] ptr_cnt(input cad_pkg::cad_mode_t m);
    unique case (m)
      cad_pkg::M_IND_LONG, cad_pkg::M_INDIDX_LONG: ptr_cnt = 2'd2;
      cad_pkg::M_IND_SHORT, cad_pkg::M_INDIDX_SHORT, cad_pkg::M_REL_IND: ptr_cnt = 2'd1;
      cad_pkg::M_BIT_IND, cad_pkg::M_BITREL_IND: ptr_cnt = 2'd1;
      default: ptr_cnt = 2'd0;
    endcase
  endfunction

  // mode implied by the opcode column, and in the immediate column by the low nibble
  function automatic cad_pkg::cad_mode_t base_mode(input logic [7:0] op);
    case (op[7:4])
      cad_pkg::COL_BITREL: base_mode = cad_pkg::M_BITREL_DIR;
      cad_pkg::COL_BIT: base_mode = cad_pkg::M_BIT_DIR;
      cad_pkg::COL_REL: base_mode = cad_pkg::M_REL_DIR;
      cad_pkg::COL_RMW_DIR: base_mode = cad_pkg::M_DIR_SHORT;
      cad_pkg::COL_RMW_IDX: base_mode = cad_pkg::M_IDX_SHORT;
      cad_pkg::COL_RMW_IDX0: base_mode = cad_pkg::M_IDX_NONE;
      cad_pkg::COL_CTRL_LO, cad_pkg::COL_CTRL_HI: base_mode = cad_pkg::M_INHERENT;
      cad_pkg::COL_INH_A, cad_pkg::COL_INH_X: base_mode = cad_pkg::M_INHERENT;
      // immediate column, except the relative call
      cad_pkg::COL_IMM: base_mode = (op[3:0] == cad_pkg::ROW_CALLR) ? cad_pkg::M_REL_DIR : cad_pkg::M_IMMEDIATE;
      // short and long columns kept apart
      cad_pkg::COL_DIR: base_mode = cad_pkg::M_DIR_SHORT;
      cad_pkg::COL_DIR_L: base_mode = cad_pkg::M_DIR_LONG;
      cad_pkg::COL_IDX_L: base_mode = cad_pkg::M_IDX_LONG;
      cad_pkg::COL_IDX: base_mode = cad_pkg::M_IDX_SHORT;
      default: base_mode = cad_pkg::M_IDX_NONE;
    endcase
  endfunction

  // Indirect prefix turns direct or offset-indexed forms into their indirect forms; the indirect Y prefix only the indexed ones
  function automatic cad_pkg::cad_mode_t pfx_mode(input cad_pkg::cad_mode_t m, input logic [1:0] p);
    pfx_mode = m;
    if (p == cad_pkg::PSEL_IND) begin
      unique case (m)
        cad_pkg::M_DIR_SHORT: pfx_mode = cad_pkg::M_IND_SHORT;
        cad_pkg::M_DIR_LONG: pfx_mode = cad_pkg::M_IND_LONG;
        cad_pkg::M_IDX_SHORT: pfx_mode = cad_pkg::M_INDIDX_SHORT;
        cad_pkg::M_IDX_LONG: pfx_mode = cad_pkg::M_INDIDX_LONG;
        cad_pkg::M_REL_DIR: pfx_mode = cad_pkg::M_REL_IND;
        cad_pkg::M_BIT_DIR: pfx_mode = cad_pkg::M_BIT_IND;
        cad_pkg::M_BITREL_DIR: pfx_mode = cad_pkg::M_BITREL_IND;
        default: pfx_mode = m;
      endcase
    end else if (p == cad_pkg::PSEL_INDY) begin
      unique case (m)
        cad_pkg::M_IDX_SHORT: pfx_mode = cad_pkg::M_INDIDX_SHORT;
        cad_pkg::M_IDX_LONG: pfx_mode = cad_pkg::M_INDIDX_LONG;
        default: pfx_mode = m;
      endcase
    end
  endfunction

  cad_state_t state_q;
  cad_state_t state_d;
  logic [1:0] pfx_q;
  logic [1:0] pfx_d;
  logic [7:0] op_q;
  logic [7:0] op_d;
  cad_pkg::cad_mode_t mode_q;
  cad_pkg::cad_mode_t mode_d;
  logic [1:0] fcnt_q;
  logic [1:0] fcnt_d;
  logic [1:0] pcnt_q;
  logic [1:0] pcnt_d;
  logic [1:0] pidx_q;
  logic [1:0] pidx_d;
  logic [15:0] pc_q;
  logic [15:0] pc_d;
  logic [2:0] len_q;
  logic [2:0] len_d;

  // Output flops
  logic use_y_q;
  logic use_y_d;
  logic rmw_q;
  logic rmw_d;
  logic [7:0] imm_q;
  logic [7:0] imm_d;
  logic [15:0] ea_q;
  logic [15:0] ea_d;
  logic [15:0] tgt_q;
  logic [15:0] tgt_d;
  logic halt_q;
  logic halt_d;
  logic wfi_q;
  logic wfi_d;

  logic take_byte;
  logic is_pfx;
  logic opc_take;
  logic opnd_take;
  logic ptr_take;
  logic [15:0] opnd_word;
  logic [15:0] ptr_word;
  logic [15:0] ea_c;
  logic [15:0] tgt_c;
  logic [7:0] ptr_base;
  cad_pkg::cad_mode_t new_mode;
  logic [1:0] new_fcnt;

  assign o_fetch_ready = (state_q == S_OPC) || (state_q == S_OPND);
  assign take_byte = o_fetch_ready && i_fetch_valid;
  assign is_pfx = (pfx_q == cad_pkg::PSEL_NONE) &&
    ((i_fetch_byte == cad_pkg::PFX_Y) || (i_fetch_byte == cad_pkg::PFX_INDY) || (i_fetch_byte == cad_pkg::PFX_IND));
  assign opc_take = take_byte && (state_q == S_OPC) && !is_pfx;
  assign opnd_take = take_byte && (state_q == S_OPND);
  assign ptr_take = (state_q == S_PTR) && i_mem_valid;
  assign new_mode = pfx_mode(base_mode(i_fetch_byte), pfx_q);
  assign new_fcnt = fetch_cnt(new_mode);
  // Bit-relative forms carry the pointer address in the first of two bytes
  assign ptr_base = (mode_q == cad_pkg::M_BITREL_IND) ? opnd_word[15:8] : opnd_word[7:0];

  // pointer read after the pointer address byte
  assign o_mem_rd = (state_q == S_PTR);
  assign o_mem_addr = {cad_pkg::PAGE0_HI, ptr_base} + {14'h0000, pidx_q};

  cad_word_asm u_opnd (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_clear(opc_take),
    .i_load(opnd_take),
    .i_byte(i_fetch_byte),
    .o_word(opnd_word)
  );

  cad_word_asm u_ptr (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_clear(opc_take),
    .i_load(ptr_take),
    .i_byte(i_mem_rdata),
    .o_word(ptr_word)
  );

  cad_ea_calc u_ea (
    .i_mode(mode_q),
    .i_opnd(opnd_word),
    .i_ptr(ptr_word),
    .i_idx(use_y_q ? i_idx_y : i_idx_x),
    .i_pc(pc_q),
    .o_ea(ea_c),
    .o_target(tgt_c)
  );

  // Sequencer
  always_comb begin
    state_d = state_q;
    pfx_d = pfx_q;
    op_d = op_q;
    mode_d = mode_q;
    fcnt_d = fcnt_q;
    pcnt_d = pcnt_q;
    pidx_d = pidx_q;
    len_d = len_q;
    pc_d = take_byte ? pc_q + 16'h0001 : pc_q;
    if (i_pc_load) begin
      pc_d = i_pc_value;
    end
    unique case (state_q)
      S_OPC: begin
        if (take_byte && is_pfx) begin
          if (i_fetch_byte == cad_pkg::PFX_Y) begin
            pfx_d = cad_pkg::PSEL_Y;
          end else if (i_fetch_byte == cad_pkg::PFX_INDY) begin
            pfx_d = cad_pkg::PSEL_INDY;
          end else begin
            pfx_d = cad_pkg::PSEL_IND;
          end
          len_d = len_q + 3'd1;
        end else if (opc_take) begin
          op_d = i_fetch_byte;
          mode_d = new_mode;
          fcnt_d = new_fcnt;
          pcnt_d = ptr_cnt(new_mode);
          pidx_d = 2'd0;
          // a Y prefix is the extra byte of no-offset indexing
          len_d = len_q + cad_pkg::LEN_OPCODE + {1'b0, new_fcnt};
          if (new_fcnt != 2'd0) begin
            state_d = S_OPND;
          end else begin
            state_d = S_CALC;
          end
        end
      end
      S_OPND: begin
        if (opnd_take) begin
          fcnt_d = fcnt_q - 2'd1;
          if (fcnt_q == 2'd1) begin
            state_d = (pcnt_q != 2'd0) ? S_PTR : S_CALC;
          end
        end
      end
      S_PTR: begin
        if (ptr_take) begin
          pidx_d = pidx_q + 2'd1;
          if (pidx_q + 2'd1 == pcnt_q) begin
            state_d = S_CALC;
          end
        end
      end
      S_CALC: begin
        state_d = S_OUT;
      end
      S_OUT: begin
        if (i_dec_ready) begin
          state_d = S_OPC;
          pfx_d = cad_pkg::PSEL_NONE;
          len_d = 3'd0;
        end
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= S_OPC;
      pfx_q <= cad_pkg::PSEL_NONE;
      op_q <= 8'h00;
      mode_q <= cad_pkg::M_INHERENT;
      fcnt_q <= 2'd0;
      pcnt_q <= 2'd0;
      pidx_q <= 2'd0;
      len_q <= 3'd0;
      pc_q <= cad_pkg::PC_RST;
    end else begin
      state_q <= state_d;
      pfx_q <= pfx_d;
      op_q <= op_d;
      mode_q <= mode_d;
      fcnt_q <= fcnt_d;
      pcnt_q <= pcnt_d;
      pidx_q <= pidx_d;
      len_q <= len_d;
      pc_q <= pc_d;
    end
  end

  // Result capture; index read at this cycle so the datapath must hold it
  always_comb begin
    use_y_d = use_y_q;
    rmw_d = rmw_q;
    imm_d = imm_q;
    ea_d = ea_q;
    tgt_d = tgt_q;
    halt_d = halt_q;
    wfi_d = wfi_q;
    if (opc_take) begin
      // Y for the Y prefix and the indirect Y prefix
      use_y_d = (pfx_q == cad_pkg::PSEL_Y) || (pfx_q == cad_pkg::PSEL_INDY);
      rmw_d = (i_fetch_byte[7:4] == cad_pkg::COL_RMW_DIR) || (i_fetch_byte[7:4] == cad_pkg::COL_RMW_IDX) ||
        (i_fetch_byte[7:4] == cad_pkg::COL_RMW_IDX0) || (i_fetch_byte[7:4] == cad_pkg::COL_BIT) ||
        (i_fetch_byte[7:4] == cad_pkg::COL_BITREL);
      halt_d = (i_fetch_byte == cad_pkg::OP_HALT);
      wfi_d = (i_fetch_byte == cad_pkg::OP_WFI);
    end
    if (state_q == S_CALC) begin
      // second byte is the operand value
      imm_d = opnd_word[7:0];
      ea_d = ea_c;
      tgt_d = tgt_c;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      use_y_q <= 1'b0;
      rmw_q <= 1'b0;
      imm_q <= 8'h00;
      ea_q <= 16'h0000;
      tgt_q <= 16'h0000;
      halt_q <= 1'b0;
      wfi_q <= 1'b0;
    end else begin
      use_y_q <= use_y_d;
      rmw_q <= rmw_d;
      imm_q <= imm_d;
      ea_q <= ea_d;
      tgt_q <= tgt_d;
      halt_q <= halt_d;
      wfi_q <= wfi_d;
    end
  end

  assign o_pc = pc_q;
  assign o_dec_valid = (state_q == S_OUT);
  assign o_dec_opcode = op_q;
  assign o_dec_mode = mode_q;
  assign o_dec_len = len_q;
  assign o_dec_use_y = use_y_q;
  assign o_dec_rmw = rmw_q;
  assign o_dec_imm = imm_q;
  assign o_dec_ea = ea_q;
  assign o_dec_target = tgt_q;
  assign o_dec_bit = op_q[3:1];
  assign o_dec_halt = halt_q;
  assign o_dec_wfi = wfi_q;

endmodule

// ### testbench/cad_decoder_asserts.sv
// Port-level concurrent checks for the addressing-mode decoder
`timescale 1ns/1ps
module cad_decoder_asserts (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Fetch and program counter
  input wire logic i_fetch_valid,
  input wire logic o_fetch_ready,
  input wire logic i_pc_load,
  input wire logic [15:0] o_pc,
  // Pointer reads
  input wire logic o_mem_rd,
  input wire logic [15:0] o_mem_addr,
  input wire logic i_mem_valid,
  // Decode result
  input wire logic o_dec_valid,
  input wire logic i_dec_ready,
  input wire logic [7:0] o_dec_opcode,
  input wire cad_pkg::cad_mode_t o_dec_mode,
  input wire logic [2:0] o_dec_len,
  input wire logic o_dec_use_y,
  input wire logic o_dec_rmw,
  input wire logic [15:0] o_dec_ea,
  input wire logic [15:0] o_dec_target,
  input wire logic o_dec_halt
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  sequence s_ptr_byte;
    o_mem_rd && i_mem_valid;
  endsequence
  sequence s_shown(cad_pkg::cad_mode_t m);
    o_dec_valid && o_dec_mode == m;
  endsequence
  a_inh_len: assert property (s_shown(cad_pkg::M_INHERENT) |->
    o_dec_len == 3'h1 + o_dec_use_y) else $error("inherent length wrong");
  a_imm_len: assert property (s_shown(cad_pkg::M_IMMEDIATE) |->
    o_dec_len == 3'h2 + o_dec_use_y) else $error("immediate length wrong");
  a_idx0_len: assert property (s_shown(cad_pkg::M_IDX_NONE) |->
    o_dec_len == 3'h1 + o_dec_use_y && o_dec_ea[15:8] == 8'h00) else $error("no-offset indexed wrong");
  a_halt_inh: assert property (o_dec_valid && o_dec_halt |->
    o_dec_opcode == cad_pkg::OP_HALT && o_dec_mode == cad_pkg::M_INHERENT) else $error("halt decode wrong");
  a_rmw_short: assert property (o_dec_valid && o_dec_rmw |-> !(o_dec_mode inside {cad_pkg::M_DIR_LONG,
    cad_pkg::M_IDX_LONG, cad_pkg::M_IND_LONG, cad_pkg::M_INDIDX_LONG})) else $error("long memory rmw");
  a_short_page: assert property (s_shown(cad_pkg::M_DIR_SHORT) |->
    o_dec_ea[15:8] == cad_pkg::PAGE0_HI) else $error("short direct left page zero");
  a_idx_sum: assert property (s_shown(cad_pkg::M_IDX_SHORT) |->
    o_dec_ea <= 16'h01FE) else $error("short indexed out of range");
  a_ptr_page: assert property (o_mem_rd && !$past(o_mem_rd) |->
    o_mem_addr[15:8] == 8'h00) else $error("pointer address not in page zero");
  a_ptr_hold: assert property (o_mem_rd && !i_mem_valid |=>
    o_mem_rd && $stable(o_mem_addr)) else $error("pointer read dropped early");
  a_ptr_step: assert property (s_ptr_byte ##1 o_mem_rd |->
    o_mem_addr == $past(o_mem_addr) + 16'h1) else $error("word pointer address did not step");
  a_rel_range: assert property (s_shown(cad_pkg::M_REL_DIR) |->
    16'(o_dec_target - o_pc + 16'h0080) < 16'h0100) else $error("relative target out of range");
  a_pc_step: assert property (o_fetch_ready && i_fetch_valid && !i_pc_load |=>
    o_pc == $past(o_pc) + 16'h1) else $error("pc did not count byte");
  a_dec_hold: assert property (o_dec_valid && !i_dec_ready |=>
    o_dec_valid && $stable(o_dec_mode) && $stable(o_dec_ea)) else $error("decode result not held");
endmodule

bind cad_decoder cad_decoder_asserts u_chk (.i_sys_clk, .i_rst, .i_fetch_valid, .o_fetch_ready, .i_pc_load,
  .o_pc, .o_mem_rd, .o_mem_addr, .i_mem_valid, .o_dec_valid, .i_dec_ready, .o_dec_opcode, .o_dec_mode,
  .o_dec_len, .o_dec_use_y, .o_dec_rmw, .o_dec_ea, .o_dec_target, .o_dec_halt);

// ### testbench/cad_mem_model.sv
// Data memory partner answering pointer reads after a chosen delay
`timescale 1ns/1ps
module cad_mem_model (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Read request and delay
  input wire logic i_mem_rd,
  input wire logic [15:0] i_mem_addr,
  input wire logic [1:0] i_lat,
  // Read answer
  output logic o_mem_valid,
  output logic [7:0] o_mem_rdata
);
  logic [1:0] wait_q;
  logic [1:0] wait_d;
  logic [7:0] last_q;
  logic [7:0] last_d;
  always_comb begin
    o_mem_valid = i_mem_rd && (wait_q == i_lat);
    // Contents follow the address; off-cycle the bus shows the inverse of the last byte
    o_mem_rdata = o_mem_valid ? i_mem_addr[7:0] + 8'h11 : ~last_q;
    wait_d = (o_mem_valid || !i_mem_rd) ? 2'h0 : wait_q + 2'h1;
    last_d = o_mem_valid ? o_mem_rdata : last_q;
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      wait_q <= 2'h0;
      last_q <= 8'h00;
    end else begin
      wait_q <= wait_d;
      last_q <= last_d;
    end
  end
endmodule

// ### testbench/cad_decoder_tb_top.sv
// Self-checking bench for the addressing-mode decoder
`timescale 1ns/1ps
module cad_decoder_tb_top;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_fetch_valid = 1'b0;
  logic [7:0] i_fetch_byte = 8'h00;
  logic i_pc_load = 1'b0;
  logic [15:0] i_pc_value = 16'h0000;
  logic [7:0] i_idx_x = 8'hF0;
  logic [7:0] i_idx_y = 8'h10;
  logic i_dec_ready = 1'b0;
  logic [1:0] lat = 2'h0;
  logic o_fetch_ready, o_mem_rd, i_mem_valid, o_dec_valid, o_dec_use_y, o_dec_rmw, o_dec_halt, o_dec_wfi;
  logic [15:0] o_pc, o_mem_addr, o_dec_ea, o_dec_target;
  logic [7:0] i_mem_rdata, o_dec_opcode, o_dec_imm;
  logic [2:0] o_dec_len, o_dec_bit;
  cad_pkg::cad_mode_t o_dec_mode;
  int err_count = 0;
  int cmp_count = 0;
  always #2.5 i_sys_clk = ~i_sys_clk;
  cad_decoder uut (.i_sys_clk, .i_rst, .i_fetch_valid, .i_fetch_byte, .o_fetch_ready, .i_pc_load, .i_pc_value,
    .o_pc, .i_idx_x, .i_idx_y, .o_mem_rd, .o_mem_addr, .i_mem_valid, .i_mem_rdata, .o_dec_valid, .i_dec_ready,
    .o_dec_opcode, .o_dec_mode, .o_dec_len, .o_dec_use_y, .o_dec_rmw, .o_dec_imm, .o_dec_ea, .o_dec_target,
    .o_dec_bit, .o_dec_halt, .o_dec_wfi);
  cad_mem_model u_mem (.i_sys_clk, .i_rst, .i_mem_rd(o_mem_rd), .i_mem_addr(o_mem_addr), .i_lat(lat),
    .o_mem_valid(i_mem_valid), .o_mem_rdata(i_mem_rdata));
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Byte is held until an edge sees ready high
  task automatic send(input logic [7:0] b);
    i_fetch_valid = 1'b1;
    i_fetch_byte = b;
    for (int k = 0; k < 40 && o_fetch_ready !== 1'b1; k++) begin
      @(posedge i_sys_clk);
      #1;
    end
    // A byte that is never taken counts as a mismatch
    chk(o_fetch_ready, 1'b1);
    @(posedge i_sys_clk);
    #1;
  endtask
  task automatic op1(input logic [7:0] b);
    send(b);
    i_fetch_valid = 1'b0;
    i_fetch_byte = ~b;
  endtask
  task automatic op2(input logic [15:0] w);
    send(w[15:8]);
    op1(w[7:0]);
  endtask
  task automatic op3(input logic [23:0] w);
    send(w[23:16]);
    op2(w[15:0]);
  endtask
  task automatic pcld(input logic [15:0] v);
    i_pc_load = 1'b1;
    i_pc_value = v;
    @(posedge i_sys_clk);
    #1;
    i_pc_load = 1'b0;
  endtask
  // s selects the address compare: 0 ea, 1 target, 2 none
  task automatic get(input cad_pkg::cad_mode_t m, input logic [2:0] l, input logic [15:0] v, input logic [1:0] s);
    for (int k = 0; k < 40 && o_dec_valid !== 1'b1; k++) begin
      @(posedge i_sys_clk);
      #1;
    end
    chk(o_dec_valid, 1'b1);
    chk(o_dec_mode, m);
    chk(o_dec_len, l);
    if (s == 2'h0) chk(o_dec_ea, v);
    else if (s == 2'h1) chk(o_dec_target, v);
    i_dec_ready = 1'b1;
    @(posedge i_sys_clk);
    #1;
    i_dec_ready = 1'b0;
    chk(o_fetch_ready, 1'b1);
  endtask
  task automatic t_inh;
    logic [7:0] ops [4] = '{8'h9D, 8'h8E, 8'h8F, 8'h4C};
    for (int i = 0; i < 4; i++) begin
      op1(ops[i]);
      get(cad_pkg::M_INHERENT, 3'h1, 16'h0000, 2'h2);
      chk({o_dec_halt, o_dec_wfi}, {ops[i] == 8'h8E, ops[i] == 8'h8F});
    end
    op2(16'h905C);
    get(cad_pkg::M_INHERENT, 3'h2, 16'h0000, 2'h2);
    chk(o_dec_use_y, 1'b1);
  endtask
  task automatic t_imm;
    op2(16'hA655);
    get(cad_pkg::M_IMMEDIATE, 3'h2, 16'h0000, 2'h2);
    chk(o_dec_imm, 8'h55);
  endtask
  task automatic t_dir;
    op3(24'hC61000);
    repeat (3) @(posedge i_sys_clk);
    #1;
    get(cad_pkg::M_DIR_LONG, 3'h3, 16'h1000, 2'h0);
    chk(o_dec_rmw, 1'b0);
    op2(16'hB680);
    get(cad_pkg::M_DIR_SHORT, 3'h2, 16'h0080, 2'h0);
    op2(16'h3C10);
    get(cad_pkg::M_DIR_SHORT, 3'h2, 16'h0010, 2'h0);
    chk(o_dec_rmw, 1'b1);
  endtask
  task automatic t_idx;
    op1(8'hF6);
    get(cad_pkg::M_IDX_NONE, 3'h1, 16'h00F0, 2'h0);
    op2(16'h90F6);
    get(cad_pkg::M_IDX_NONE, 3'h2, 16'h0010, 2'h0);
    op2(16'hE6FF);
    get(cad_pkg::M_IDX_SHORT, 3'h2, 16'h01EF, 2'h0);
    op3(24'hD61234);
    get(cad_pkg::M_IDX_LONG, 3'h3, 16'h1324, 2'h0);
  endtask
  task automatic t_rel;
    pcld(16'h1000);
    op2(16'h2780);
    get(cad_pkg::M_REL_DIR, 3'h2, 16'h0F82, 2'h1);
    op2(16'h277F);
    get(cad_pkg::M_REL_DIR, 3'h2, 16'h1083, 2'h1);
    op2(16'hAD10);
    get(cad_pkg::M_REL_DIR, 3'h2, 16'h1016, 2'h1);
    op3(24'h018005);
    get(cad_pkg::M_BITREL_DIR, 3'h3, 16'h100E, 2'h1);
    op2(16'h1E80);
    get(cad_pkg::M_BIT_DIR, 3'h2, 16'h0080, 2'h0);
    chk(o_dec_bit, 3'h7);
  endtask
  task automatic t_ind;
    pcld(16'h2000);
    op3(24'h922740);
    get(cad_pkg::M_REL_IND, 3'h3, 16'h2054, 2'h1);
    send(8'h92);
    op3(24'h014005);
    get(cad_pkg::M_BITREL_IND, 3'h4, 16'h200C, 2'h1);
    op3(24'h92B640);
    get(cad_pkg::M_IND_SHORT, 3'h3, 16'h0051, 2'h0);
    lat = 2'h2;
    op3(24'h92C640);
    get(cad_pkg::M_IND_LONG, 3'h3, 16'h5152, 2'h0);
    op3(24'h92C6FF);
    get(cad_pkg::M_IND_LONG, 3'h3, 16'h1011, 2'h0);
    op3(24'h91E640);
    get(cad_pkg::M_INDIDX_SHORT, 3'h3, 16'h0061, 2'h0);
    chk(o_dec_use_y, 1'b1);
    op3(24'h91D640);
    get(cad_pkg::M_INDIDX_LONG, 3'h3, 16'h5162, 2'h0);
    op3(24'h92E640);
    get(cad_pkg::M_INDIDX_SHORT, 3'h3, 16'h0141, 2'h0);
    op3(24'h921E40);
    get(cad_pkg::M_BIT_IND, 3'h3, 16'h0051, 2'h0);
    lat = 2'h0;
  endtask
  initial begin
    repeat (20) @(posedge i_sys_clk);
    #1;
    i_rst = 1'b0;
    t_inh();
    t_imm();
    t_dir();
    t_idx();
    t_rel();
    t_ind();
    complete_run();
  end
  // Whole sequence needs well under a thousand cycles
  initial begin
    #20000;
    err_count++;
    complete_run();
  end
endmodule
